// >>> src/ebm_lane.sv
`timescale 1ns/1ns
module ebm_lane
  import ebm_pkg::*;
(
  input wire logic [1:0] i_size,
  input wire logic i_offset,
  input wire logic [31:0] i_wdata,
  input wire logic [1:0] i_done,
  output logic [15:0] o_lanes
);
  logic [7:0] byte0;
  logic [7:0] byte1;
  logic [2:0] idx;
  always_comb begin
    // Bytes still owed begin at index done; operand byte zero is most significant
    idx = {1'b0, i_done};
    byte0 = i_wdata[31 - 8*idx -: 8];
    byte1 = (idx == STEP_COUNT) ? byte0 : i_wdata[23 - 8*idx -: 8];
    if (i_size == SIZE_BYTE || i_offset) begin
      o_lanes = {byte0, byte0};
    end else begin
      o_lanes = {byte0, byte1};
    end
  end
endmodule // ebm_lane

// >>> src/ebm_master.sv
`timescale 1ns/1ns
// Overview of operation
// - Drive size code of bytes still to move: byte, word, three, long.
// - Space code top bit always one; data, program or control space 7.
// - Space code stable whenever address-valid strobe is asserted.
// - Low twenty lines carry most significant byte address; upper four copy bit 19.
// - Address-valid strobe asserts half a clock after cycle start.
// - Read data captured on final falling edge of the cycle.
// - Write cycles drive all sixteen data lines.
// - Write data driven half a clock after address-valid strobe.
// - Read: data timing strobe asserts with address-valid strobe.
// - Write: data timing strobe one clock after address-valid strobe.
// - Ack pair: both high waits, narrow ends 8-bit, wide ends 16-bit, both low reserved.
// - Bus fault ends cycle; with stop request also asserted, bus error taken.
// - Autovector ends interrupt-acknowledge cycles only; ignored elsewhere.
// - Autovector held asserted gives autovectors for every external interrupt.
// - Each cycle assumes a 16-bit port and tries widest transfer.
// - Long word via 16-bit port: high word first, low word next.
// - Long-word read from 8-bit port takes four byte cycles.
// - Odd-offset word or long is misaligned; one cycle moves one aligned word at most.
// - Misaligned long word runs as two misaligned word transfers.
// - Operand byte zero is most significant.
// - Bytes per cycle never exceed size code; remaining bytes follow.
module ebm_master
  import ebm_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_reset,
  input wire logic i_req_valid,
  input wire ebm_req_t i_req,
  output logic o_req_ready,
  output ebm_resp_t o_resp,
  output logic o_resp_valid,
  input wire ebm_term_t i_term,
  input wire logic [DATA_WIDTH-1:0] i_data,
  output ebm_pins_t o_pins
);
  // Phases: each clock is split into a rising-edge half (H) and falling-edge half
  typedef enum logic [2:0] {
    EBM_IDLE,
    EBM_START,
    EBM_ADDR,
    EBM_DATA,
    EBM_WAIT,
    EBM_END
  } ebm_phase_t;

  typedef struct packed {
    ebm_phase_t phase;
    ebm_req_t req;
    logic [1:0] done;
    logic [ADDR_WIDTH-1:0] addr;
    logic [1:0] size;
    logic [31:0] rdata;
    logic [1:0] take;
    logic fault;
    logic bus_error;
    logic autovector;
    logic resp_valid;
    ebm_resp_t resp;
    logic as_n;
    logic ds_n;
    logic oe;
    logic [DATA_WIDTH-1:0] dout;
  } ebm_state_t;

  ebm_state_t state;
  ebm_state_t next_state;
  logic [15:0] lanes;
  logic [15:0] fall_data;
  logic [15:0] fall_rdata;
  logic fall_as_n;
  logic fall_oe;

  function automatic logic [1:0] ebm_size_code(input logic [2:0] left);
    case (left)
      3'h1: ebm_size_code = SIZE_BYTE;
      3'h2: ebm_size_code = SIZE_WORD;
      3'h3: ebm_size_code = SIZE_THREE;
      default: ebm_size_code = SIZE_LONG;
    endcase
  endfunction

  function automatic logic [2:0] ebm_bytes(input logic [1:0] code);
    case (code)
      SIZE_BYTE: ebm_bytes = 3'h1;
      SIZE_WORD: ebm_bytes = 3'h2;
      SIZE_THREE: ebm_bytes = 3'h3;
      default: ebm_bytes = 3'h4;
    endcase
  endfunction

  function automatic logic [2:0] ebm_space(input ebm_kind_t kind);
    case (kind)
      EBM_KIND_PROGRAM: ebm_space = SPACE_PROGRAM;
      EBM_KIND_DATA: ebm_space = SPACE_DATA;
      default: ebm_space = SPACE_CPU;
    endcase
  endfunction

  ebm_lane u_lane (
    .i_size(state.size),
    .i_offset(state.addr[BYTE_OFFSET_BIT]),
    .i_wdata(state.req.wdata),
    .i_done(state.done),
    .o_lanes(lanes)
  );

  always_comb begin
    logic [2:0] left;
    logic [2:0] moved;
    logic [2:0] total;
    logic ack_wide;
    logic ack_narrow;
    logic ack_ok;
    logic fault;
    logic auto_vector_in;
    logic [2:0] new_done;
    logic [7:0] hi_byte;
    logic [7:0] lo_byte;
    left = 3'h0;
    moved = 3'h0;
    total = 3'h0;
    new_done = 3'h0;
    // Read data come from the falling-edge latch, not from the live pins
    hi_byte = fall_rdata[15:8];
    lo_byte = fall_rdata[7:0];
    next_state = state;
    next_state.resp_valid = 1'b0;
    ack_wide = ~i_term.wide_ack_n & i_term.narrow_ack_n;
    ack_narrow = i_term.wide_ack_n & ~i_term.narrow_ack_n;
    ack_ok = ack_wide | ack_narrow;
    fault = ~i_term.bus_fault_in_n;
    auto_vector_in = ~i_term.auto_vector_in_n && state.req.kind == EBM_KIND_IACK;
    total = ebm_bytes(state.req.size);
    case (state.phase)
      EBM_IDLE: begin
        if (i_req_valid) begin
          next_state.req = i_req;
          next_state.done = 2'h0;
          next_state.addr = i_req.addr;
          // A long word at an odd address runs as two misaligned words
          if (i_req.size == SIZE_LONG && i_req.addr[BYTE_OFFSET_BIT]) begin
            next_state.size = SIZE_WORD;
          end else begin
            next_state.size = i_req.size;
          end
          next_state.rdata = 32'h0;
          next_state.fault = 1'b0;
          next_state.bus_error = 1'b0;
          next_state.autovector = 1'b0;
          next_state.phase = EBM_START;
        end
      end
      EBM_START: begin
        // Strobe goes out on the falling edge that follows this rising edge
        next_state.phase = EBM_ADDR;
        next_state.as_n = 1'b0;
        next_state.ds_n = state.req.write;
        next_state.dout = lanes;
      end
      EBM_ADDR: begin
        next_state.oe = state.req.write;
        next_state.ds_n = 1'b0;
        next_state.phase = EBM_WAIT;
      end
      EBM_WAIT: begin
        // Wait states while neither ack nor fault nor autovector shows
        if (ack_ok || fault || auto_vector_in) begin
          // Narrow ports live on the upper lane; a wide port hands an odd byte on the lower lane
          if (ack_wide && state.addr[BYTE_OFFSET_BIT]) begin
            hi_byte = fall_rdata[7:0];
          end
          // Widest transfer first; odd offset or narrow port moves one byte
          if (ack_wide && !state.addr[BYTE_OFFSET_BIT] && state.size != SIZE_BYTE) begin
            moved = 3'h2;
          end else begin
            moved = 3'h1;
          end
          left = total - {1'b0, state.done};
          if (moved > left) begin
            moved = left;
          end
          if (!state.req.write) begin
            next_state.rdata[31 - 8*state.done -: 8] = hi_byte;
            if (moved == 3'h2) begin
              next_state.rdata[23 - 8*state.done -: 8] = lo_byte;
            end
          end
          new_done = {1'b0, state.done} + moved;
          next_state.done = new_done[1:0];
          next_state.fault = fault;
          next_state.bus_error = fault & ~i_term.halt_n;
          // In an acknowledge cycle the autovector input wins over a port acknowledge
          next_state.autovector = auto_vector_in & ~fault;
          next_state.addr = state.addr + {{(ADDR_WIDTH-3){1'b0}}, moved};
          if (state.req.size == SIZE_LONG && state.req.addr[BYTE_OFFSET_BIT]) begin
            next_state.size = new_done[0] ? SIZE_BYTE : SIZE_WORD;
          end else begin
            next_state.size = ebm_size_code(left - moved);
          end
          next_state.as_n = 1'b1;
          next_state.ds_n = 1'b1;
          next_state.oe = 1'b0;
          next_state.phase = EBM_END;
          if (fault || auto_vector_in || left == moved) begin
            next_state.resp.rdata = next_state.rdata;
            next_state.resp.fault = next_state.fault;
            next_state.resp.bus_error = next_state.bus_error;
            next_state.resp.autovector = next_state.autovector;
            next_state.resp_valid = 1'b1;
            next_state.phase = EBM_IDLE;
          end else begin
            next_state.phase = EBM_START;
          end
        end
      end
      default: begin
        next_state.phase = EBM_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      state <= '0;
      state.phase <= EBM_IDLE;
      state.as_n <= 1'b1;
      state.ds_n <= 1'b1;
    end else begin
      state <= next_state;
    end
  end

  // Half-clock timing: address strobe, output-enable copy, write data and read data update on the falling edge
  always_ff @(negedge i_clk_sys) begin
    if (i_reset) begin
      fall_as_n <= 1'b1;
      fall_oe <= 1'b0;
      fall_data <= 16'h0000;
      fall_rdata <= 16'h0000;
    end else begin
      fall_as_n <= state.as_n;
      fall_oe <= state.oe;
      fall_data <= state.dout;
      fall_rdata <= i_data;
    end
  end

  always_comb begin
    o_req_ready = (state.phase == EBM_IDLE);
    o_resp = state.resp;
    o_resp_valid = state.resp_valid;
    o_pins.addr = {{UPPER_LINES{state.addr[TOP_DRIVEN_LINE]}}, state.addr};
    o_pins.size_code_hi = state.size[1];
    o_pins.size_code_lo = state.size[0];
    o_pins.space_code = ebm_space(state.req.kind);
    o_pins.read_not_write = ~state.req.write;
    o_pins.address_valid_strobe_n = fall_as_n;
    o_pins.data_timing_strobe_n = state.req.write ? (fall_as_n | state.ds_n | ~fall_oe) : (fall_as_n | state.ds_n);
    o_pins.data_out = fall_data;
    // Drivers turn on at the rising edge half a clock after the address strobe
    o_pins.data_oe = state.oe;
  end
  // Read data used at the terminating rising edge were latched on the falling edge before it
endmodule // ebm_master

// >>> src/ebm_pkg.sv
package ebm_pkg;
  localparam int CLK_PERIOD_NS = 4;
  localparam logic [1:0] SIZE_LONG = 2'h0;
  localparam logic [1:0] SIZE_BYTE = 2'h1;
  localparam logic [1:0] SIZE_WORD = 2'h2;
  localparam logic [1:0] SIZE_THREE = 2'h3;
  localparam logic [2:0] SPACE_DATA = 3'h5;
  localparam logic [2:0] SPACE_PROGRAM = 3'h6;
  localparam logic [2:0] SPACE_CPU = 3'h7;
  localparam int ADDR_WIDTH = 20;
  localparam int UPPER_LINES = 4;
  localparam int DATA_WIDTH = 16;
  localparam int TOP_DRIVEN_LINE = 19;
  localparam int BYTE_OFFSET_BIT = 0;
  localparam logic [2:0] STEP_COUNT = 3'h3;
  localparam logic [2:0] STEP_ZERO = 3'h0;
  localparam logic [2:0] STEP_ONE = 3'h1;
  localparam logic [2:0] STEP_TWO = 3'h2;

  typedef enum logic [1:0] {
    EBM_KIND_DATA,
    EBM_KIND_PROGRAM,
    EBM_KIND_CPU,
    EBM_KIND_IACK
  } ebm_kind_t;

  typedef struct packed {
    logic [ADDR_WIDTH-1:0] addr;
    logic [1:0] size;
    logic write;
    ebm_kind_t kind;
    logic [31:0] wdata;
  } ebm_req_t;

  typedef struct packed {
    logic [31:0] rdata;
    logic bus_error;
    logic fault;
    logic autovector;
  } ebm_resp_t;

  typedef struct packed {
    logic [ADDR_WIDTH+UPPER_LINES-1:0] addr;
    logic size_code_hi;
    logic size_code_lo;
    logic [2:0] space_code;
    logic read_not_write;
    logic address_valid_strobe_n;
    logic data_timing_strobe_n;
    logic [DATA_WIDTH-1:0] data_out;
    logic data_oe;
  } ebm_pins_t;

  typedef struct packed {
    logic wide_ack_n;
    logic narrow_ack_n;
    logic bus_fault_in_n;
    logic halt_n;
    logic auto_vector_in_n;
  } ebm_term_t;
endpackage

// >>> test/ebm_master_chk.sv
`timescale 1ns/1ns
module ebm_master_chk
  import ebm_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_reset,
  input wire logic o_resp_valid,
  input wire ebm_term_t i_term,
  input wire ebm_pins_t o_pins
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_reset);
  logic as;
  logic rd;
  logic quiet;
  assign as = !o_pins.address_valid_strobe_n;
  assign rd = o_pins.read_not_write;
  assign quiet = &{i_term.wide_ack_n, i_term.narrow_ack_n, i_term.bus_fault_in_n, i_term.auto_vector_in_n};
  property p_space; as |-> o_pins.space_code[2]; endproperty
  a_space: assert property (p_space) else $error("space top bit low");
  property p_hold; as && $past(as) |-> $stable({o_pins.space_code, o_pins.addr}); endproperty
  a_hold: assert property (p_hold) else $error("space or address moved");
  property p_upper; as |-> o_pins.addr[23:20] == {4{o_pins.addr[19]}}; endproperty
  a_upper: assert property (p_upper) else $error("upper lines differ");
  property p_rd_ds; as && rd |-> !o_pins.data_timing_strobe_n; endproperty
  a_rd_ds: assert property (p_rd_ds) else $error("read data strobe late");
  property p_wr_ds;
    $fell(o_pins.address_valid_strobe_n) && !rd |-> o_pins.data_timing_strobe_n ##1 !o_pins.data_timing_strobe_n;
  endproperty
  a_wr_ds: assert property (p_wr_ds) else $error("write data strobe timing");
  property p_wr_oe; as && !rd && !o_pins.data_timing_strobe_n |-> o_pins.data_oe; endproperty
  a_wr_oe: assert property (p_wr_oe) else $error("write data not driven");
  property p_wait; as && quiet |=> as; endproperty
  a_wait: assert property (p_wait) else $error("cycle ended without termination");
  property p_resp; as && !i_term.wide_ack_n && i_term.narrow_ack_n |-> ##[1:60] o_resp_valid; endproperty
  a_resp: assert property (p_resp) else $error("no response after ack");
  property p_mis; as && o_pins.addr[0] |-> {o_pins.size_code_hi, o_pins.size_code_lo} != SIZE_LONG; endproperty
  a_mis: assert property (p_mis) else $error("long cycle at odd address");
endmodule // ebm_master_chk

// >>> test/ebm_slave_model.sv
`timescale 1ns/1ns
module ebm_slave_model
  import ebm_pkg::*;
(
  input wire logic i_clk_sys,
  input wire ebm_pins_t i_pins,
  input wire logic i_port16,
  input wire logic [3:0] i_waits,
  input wire logic i_fault,
  input wire logic i_halt,
  input wire logic i_auto_vector_in,
  output ebm_term_t o_term,
  output logic [15:0] o_data,
  output logic [15:0] o_wr
);
  logic [3:0] cnt = 4'h0;
  logic [23:0] a;
  function automatic logic [7:0] bt(input logic [23:0] x);
    return x[7:0] ^ 8'h5a;
  endfunction
  assign a = i_pins.addr;
  initial begin
    o_term = '1;
    o_data = 16'h0;
    o_wr = 16'h0;
  end
  always @(posedge i_clk_sys) begin
    if (i_pins.address_valid_strobe_n || i_pins.data_timing_strobe_n) begin
      cnt <= 4'h0;
      o_term <= '1;
      o_data <= ~o_data; // Released bus shows no stale value
    end else if (cnt < i_waits) begin
      cnt <= cnt + 4'h1;
    end else begin
      o_term.wide_ack_n <= !(i_port16 && !i_fault);
      o_term.narrow_ack_n <= !(!i_port16 && !i_fault);
      o_term.bus_fault_in_n <= !i_fault;
      o_term.halt_n <= !i_halt;
      o_term.auto_vector_in_n <= !i_auto_vector_in;
      o_wr <= i_pins.data_out;
      if (i_port16) begin
        o_data <= a[0] ? {~bt(a), bt(a)} : {bt(a), bt(a + 24'h1)};
      end else begin
        o_data <= {bt(a), ~bt(a)};
      end
    end
  end
endmodule // ebm_slave_model

// >>> test/test_async_external_bus_master.sv
`timescale 1ns/1ns
module test_async_external_bus_master
  import ebm_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic req_valid = 1'b0;
  ebm_req_t req = '0;
  logic ready;
  ebm_resp_t resp;
  logic resp_valid;
  ebm_term_t term;
  logic [15:0] data;
  ebm_pins_t pins;
  logic port16 = 1'b1;
  logic [3:0] waits = 4'h0;
  logic fault = 1'b0;
  logic halt = 1'b0;
  logic auto_vector_in = 1'b0;
  logic [15:0] wr;
  logic [2:0] sp;
  int as_cnt = 0;
  int error_cnt = 0;
  int n_tests = 0;
  ebm_master dut (.i_clk_sys(clk), .i_reset(rst), .i_req_valid(req_valid), .i_req(req), .o_req_ready(ready),
    .o_resp(resp), .o_resp_valid(resp_valid), .i_term(term), .i_data(data), .o_pins(pins));
  ebm_slave_model u_slave (.i_clk_sys(clk), .i_pins(pins), .i_port16(port16), .i_waits(waits), .i_fault(fault),
    .i_halt(halt), .i_auto_vector_in(auto_vector_in), .o_term(term), .o_data(data), .o_wr(wr));
  always #2 clk = ~clk;
  always @(negedge pins.address_valid_strobe_n) begin
    as_cnt++;
    sp = pins.space_code;
  end
  function automatic logic [7:0] bt(input logic [19:0] x);
    return x[7:0] ^ 8'h5a;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic op(input logic [19:0] ad, input logic [1:0] sz, input logic w, input ebm_kind_t k,
    input logic [31:0] wd);
    int i;
    @(posedge clk);
    as_cnt = 0;
    req_valid <= 1'b1;
    req <= '{addr: ad, size: sz, write: w, kind: k, wdata: wd};
    @(posedge clk);
    while (ready !== 1'b1) @(posedge clk);
    req_valid <= 1'b0;
    for (i = 0; i < 300 && resp_valid !== 1'b1; i++) @(posedge clk);
    chk(i < 300, 1'b1);
  endtask
  task automatic t_long(input logic p16, input logic [3:0] ws, input logic [19:0] ad, input int n);
    port16 <= p16;
    waits <= ws;
    op(ad, SIZE_LONG, 1'b0, EBM_KIND_DATA, 32'h0);
    chk(resp.rdata, {bt(ad), bt(ad + 20'h1), bt(ad + 20'h2), bt(ad + 20'h3)});
    if (n > 0) chk(as_cnt, n);
    $display("long read at %h done", ad);
  endtask
  task automatic t_space();
    ebm_kind_t k;
    logic [2:0] exp [4] = '{SPACE_DATA, SPACE_PROGRAM, SPACE_CPU, SPACE_CPU};
    port16 <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      k = ebm_kind_t'(i);
      op(20'h05000, SIZE_WORD, 1'b0, k, 32'h0);
      chk(sp, exp[i]);
    end
    $display("space codes done");
  endtask
  task automatic t_write();
    op(20'h04000, SIZE_WORD, 1'b1, EBM_KIND_DATA, 32'hbeef0000);
    chk(wr, 16'hbeef);
    port16 <= 1'b0;
    op(20'h04003, SIZE_BYTE, 1'b1, EBM_KIND_DATA, 32'ha5000000);
    chk(wr, 16'ha5a5);
    $display("writes done");
  endtask
  task automatic t_term();
    port16 <= 1'b1;
    fault <= 1'b1;
    for (int h = 0; h < 2; h++) begin
      halt <= h[0];
      op(20'h06000, SIZE_BYTE, 1'b0, EBM_KIND_DATA, 32'h0);
      chk({resp.fault, resp.bus_error}, {1'b1, h[0]});
    end
    fault <= 1'b0;
    halt <= 1'b0;
    auto_vector_in <= 1'b1;
    op(20'h06002, SIZE_BYTE, 1'b0, EBM_KIND_DATA, 32'h0);
    chk(resp.autovector, 1'b0);
    for (int j = 0; j < 2; j++) begin
      op(20'h0000e, SIZE_WORD, 1'b0, EBM_KIND_IACK, 32'h0);
      chk(resp.autovector, 1'b1);
    end
    auto_vector_in <= 1'b0;
    $display("terminations done");
  endtask
  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    t_long(1'b1, 4'h0, 20'h01000, 2);
    t_long(1'b0, 4'h2, 20'h02004, 4);
    t_long(1'b1, 4'h1, 20'h03007, 4);
    t_space();
    t_write();
    t_term();
    summarize();
  end
  // About fifteen operations of at most a few dozen cycles each; this leaves wide margin
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    summarize();
  end
endmodule // test_async_external_bus_master
bind ebm_master ebm_master_chk u_chk (.i_clk_sys(i_clk_sys), .i_reset(i_reset), .o_resp_valid(o_resp_valid),
  .i_term(i_term), .o_pins(o_pins));
